// ---- rtl/ebc_break_comparator.sv ----
// file: break comparator top with apb registers and interrupt
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
//Contract
// [RULE_01] pc set holds single addresses and inclusive ranges; match breaks
// [RULE_02] adding pc entries keeps earlier entries until cleared
// [RULE_03] pc clear removes entries; clearing unknown addresses raises no error
// [RULE_04] on resume, pc set is cleared or kept per resume-clear option
// [RULE_05] ram match needs address, data and direction to agree on one access
// [RULE_06] ram data pattern has a per-bit don't-care mask
// [RULE_07] one ram condition, may stay armed with pc and register conditions
// [RULE_08] each clear command disarms only its own condition
// [RULE_09] register match on a, b, four flags, x, y; each maskable
// [RULE_10] one register condition, may coexist with pc and ram conditions
// [RULE_11] register compare never stalls the cpu
// [RULE_12] x and y compare values take any 12-bit value
// [RULE_13] combined condition breaks only when pc, ram and registers all match
// [RULE_14] arming combined disarms pc, ram and register conditions
// [RULE_15] arming pc, ram or register disarms the combined condition
// [RULE_16] one combined condition; every field including pc is maskable
// [RULE_17] combined condition fires only on instructions accessing data memory
// [RULE_18] clear-all disarms every condition but keeps mode settings
// [RULE_19] all armed condition hits are ored into one break request
module ebc_break_comparator
	import ebc_pkg::*;
#(
	parameter int SLOTS = EBC_SLOTS
) (
	input  wire logic                  clk_in,
	input  wire logic                  resetn_in,
	input  wire logic                  psel_in,
	input  wire logic                  penable_in,
	input  wire logic                  pwrite_in,
	input  wire logic [EBC_ADDR_W-1:0] paddr_in,
	input  wire logic [31:0]           pwdata_in,
	output logic      [31:0]           prdata_out,
	output logic                       pready_out,
	output logic                       pslverr_out,
	input  wire logic                  cpu_step_in,
	input  wire logic                  cpu_resume_in,
	input  wire logic [EBC_PC_W-1:0]   cpu_pc_in,
	input  wire logic                  ram_access_in,
	input  wire logic                  ram_write_in,
	input  wire logic [EBC_RA_W-1:0]   ram_addr_in,
	input  wire logic [3:0]            ram_data_in,
	input  wire logic [3:0]            reg_a_in,
	input  wire logic [3:0]            reg_b_in,
	input  wire logic                  interrupt_flag_in,
	input  wire logic                  decimal_flag_in,
	input  wire logic                  zero_flag_in,
	input  wire logic                  carry_flag_in,
	input  wire logic [EBC_XY_W-1:0]   reg_x_in,
	input  wire logic [EBC_XY_W-1:0]   reg_y_in,
	output logic                       break_req_out,
	output logic                       irq_out
);
	typedef struct packed {
		logic                 resume_clear_select;
		logic [EBC_PC_W-1:0]  pc_lo;
		logic [EBC_PC_W-1:0]  pc_hi;
		logic [21:0]          ram_cond;
		logic [11:0]          reg_ab;
		logic [27:0]          reg_xy;
		logic [EBC_MSK_W-1:0] mask;
		logic                 ram_arm;
		logic                 reg_arm;
		logic                 comb_arm;
		logic [EBC_IRQ_W-1:0] irq_st;
		logic [EBC_IRQ_W-1:0] irq_mk;
		logic [31:0]          prdata;
		logic                 pready;
		logic                 pslverr;
		logic                 brk;
		logic                 irq;
	} ebc_state_t;

	ebc_state_t          q, d;
	logic                access;
	logic                fire_wr;
	logic [3:0]          cmd;
	logic                cmd_go;
	logic                pc_add;
	logic                pc_clr;
	logic                pc_flush;
	logic                pc_match;
	logic                pc_any;
	logic                pc_full;
	logic                ram_hit;
	logic                addr_eq;
	logic                ram_rest;
	logic                reg_hit;
	logic                comb_hit;
	logic                pc_hit;
	logic [7:0]          reg_eq;
	logic [3:0]          dmask;
	logic [1:0]          dir;
	logic [31:0]         rd_val;
	logic                rd_ok;

	assign access  = psel_in && penable_in;
	// writes land at the edge where pready is seen high, as the bus expects
	assign fire_wr = access && q.pready && pwrite_in;
	assign cmd_go  = fire_wr && paddr_in == EBC_OFF_CMD;
	assign cmd     = pwdata_in[3:0];

	assign pc_add   = cmd_go && cmd == EBC_CMD_PC_ADD; // [RULE_02]
	assign pc_clr   = cmd_go && cmd == EBC_CMD_PC_CLR; // [RULE_03]
	assign pc_flush = (cmd_go && (cmd == EBC_CMD_COMB_SET || cmd == EBC_CMD_CLR_ALL)) // [RULE_14] [RULE_18]
	                || (cpu_resume_in && q.resume_clear_select); // [RULE_04]

	ebc_pc_table #(
		.SLOTS (SLOTS),
		.PC_W  (EBC_PC_W)
	) u_pc_table (
		.clk_in    (clk_in),
		.resetn_in (resetn_in),
		.add_in    (pc_add),
		.clr_in    (pc_clr),
		.flush_in  (pc_flush),
		.lo_in     (q.pc_lo),
		.hi_in     (q.pc_hi),
		.pc_in     (cpu_pc_in),
		.match_out (pc_match),
		.any_out   (pc_any),
		.full_out  (pc_full)
	);

	// ram access compare shared by the ram and combined conditions
	assign dmask   = q.ram_cond[EBC_RAM_MASK_LSB +: 4];
	assign dir     = q.ram_cond[EBC_RAM_DIR_LSB +: 2];
	assign addr_eq  = ram_addr_in == q.ram_cond[EBC_RA_W-1:0]; // [RULE_05]
	assign ram_rest = ram_access_in // [RULE_05]
	                && ((ram_data_in ^ q.ram_cond[EBC_RAM_DATA_LSB +: 4]) & ~dmask) == 4'h0 // [RULE_06]
	                && (dir == EBC_DIR_ANY || (dir == EBC_DIR_WRITE) == ram_write_in);
	assign ram_hit  = ram_rest && addr_eq;

	// pure combinational compare, so the cpu never waits on it
	assign reg_eq[0] = reg_a_in == q.reg_ab[3:0]; // [RULE_11]
	assign reg_eq[1] = reg_b_in == q.reg_ab[EBC_REG_B_LSB +: 4];
	assign reg_eq[2] = interrupt_flag_in == q.reg_ab[EBC_REG_FL_LSB + 3];
	assign reg_eq[3] = decimal_flag_in == q.reg_ab[EBC_REG_FL_LSB + 2];
	assign reg_eq[4] = zero_flag_in == q.reg_ab[EBC_REG_FL_LSB + 1];
	assign reg_eq[5] = carry_flag_in == q.reg_ab[EBC_REG_FL_LSB];
	assign reg_eq[6] = reg_x_in == q.reg_xy[EBC_XY_W-1:0]; // [RULE_12]
	assign reg_eq[7] = reg_y_in == q.reg_xy[EBC_REG_Y_LSB +: EBC_XY_W]; // [RULE_12]
	assign reg_hit   = &(reg_eq | q.mask[7:0]); // [RULE_09]

	assign pc_hit   = cpu_step_in && pc_match; // [RULE_01]
	// address mask only for the combined condition; the ram condition keeps one fixed address
	assign comb_hit = ram_rest && reg_hit // [RULE_13] [RULE_17]
	                && (addr_eq || q.mask[EBC_MSK_ADDR]) // [RULE_16]
	                && (q.mask[EBC_MSK_PC] || cpu_pc_in == q.pc_lo); // [RULE_16]

	always_comb begin
		rd_ok  = 1'b1;
		rd_val = EBC_RST_WORD;
		if (paddr_in == EBC_OFF_CTRL) begin
			rd_val[0] = q.resume_clear_select;
		end else if (paddr_in == EBC_OFF_CMD) begin
			rd_val = EBC_RST_WORD;
		end else if (paddr_in == EBC_OFF_PC_LO) begin
			rd_val[EBC_PC_W-1:0] = q.pc_lo;
		end else if (paddr_in == EBC_OFF_PC_HI) begin
			rd_val[EBC_PC_W-1:0] = q.pc_hi;
		end else if (paddr_in == EBC_OFF_RAM) begin
			rd_val[21:0] = q.ram_cond;
		end else if (paddr_in == EBC_OFF_REG_AB) begin
			rd_val[11:0] = q.reg_ab;
		end else if (paddr_in == EBC_OFF_REG_XY) begin
			rd_val[27:0] = q.reg_xy;
		end else if (paddr_in == EBC_OFF_MASK) begin
			rd_val[EBC_MSK_W-1:0] = q.mask;
		end else if (paddr_in == EBC_OFF_STATUS) begin
			rd_val[4:0] = {pc_full, q.comb_arm, q.reg_arm, q.ram_arm, pc_any};
		end else if (paddr_in == EBC_OFF_IRQ_ST) begin
			rd_val[EBC_IRQ_W-1:0] = q.irq_st;
		end else if (paddr_in == EBC_OFF_IRQ_MK) begin
			rd_val[EBC_IRQ_W-1:0] = q.irq_mk;
		end else begin
			rd_ok = 1'b0;
		end
	end

	always_comb begin
		d = q;
		// one wait state: pready rises in the second access cycle
		d.pready  = access && !q.pready;
		d.pslverr = access && !q.pready && !rd_ok;
		if (access && !q.pready) begin
			d.prdata = pwrite_in ? EBC_RST_WORD : rd_val;
		end
		if (fire_wr) begin
			if (paddr_in == EBC_OFF_CTRL) begin
				d.resume_clear_select = pwdata_in[0]; // [RULE_04]
			end else if (paddr_in == EBC_OFF_PC_LO) begin
				d.pc_lo = pwdata_in[EBC_PC_W-1:0];
			end else if (paddr_in == EBC_OFF_PC_HI) begin
				d.pc_hi = pwdata_in[EBC_PC_W-1:0];
			end else if (paddr_in == EBC_OFF_RAM) begin
				d.ram_cond = pwdata_in[21:0];
			end else if (paddr_in == EBC_OFF_REG_AB) begin
				d.reg_ab = pwdata_in[11:0];
			end else if (paddr_in == EBC_OFF_REG_XY) begin
				d.reg_xy = pwdata_in[27:0]; // [RULE_12]
			end else if (paddr_in == EBC_OFF_MASK) begin
				d.mask = pwdata_in[EBC_MSK_W-1:0]; // [RULE_16]
			end else if (paddr_in == EBC_OFF_IRQ_ST) begin
				d.irq_st = q.irq_st & ~pwdata_in[EBC_IRQ_W-1:0];
			end else if (paddr_in == EBC_OFF_IRQ_MK) begin
				d.irq_mk = pwdata_in[EBC_IRQ_W-1:0];
			end
		end
		if (cmd_go) begin
			case (cmd)
				EBC_CMD_PC_ADD: begin
					d.comb_arm = 1'b0; // [RULE_15]
				end
				EBC_CMD_RAM_SET: begin
					d.ram_arm  = 1'b1; // [RULE_07]
					d.comb_arm = 1'b0; // [RULE_15]
				end
				EBC_CMD_RAM_CLR: begin
					d.ram_arm = 1'b0; // [RULE_08]
				end
				EBC_CMD_REG_SET: begin
					d.reg_arm  = 1'b1; // [RULE_10]
					d.comb_arm = 1'b0; // [RULE_15]
				end
				EBC_CMD_REG_CLR: begin
					d.reg_arm = 1'b0; // [RULE_08]
				end
				EBC_CMD_COMB_SET: begin
					d.comb_arm = 1'b1; // [RULE_14]
					d.ram_arm  = 1'b0;
					d.reg_arm  = 1'b0;
				end
				EBC_CMD_COMB_CLR: begin
					d.comb_arm = 1'b0; // [RULE_08]
				end
				EBC_CMD_CLR_ALL: begin
					d.ram_arm  = 1'b0; // [RULE_18]
					d.reg_arm  = 1'b0;
					d.comb_arm = 1'b0;
				end
				default: begin
					d.comb_arm = q.comb_arm;
				end
			endcase
		end
		// registered request: the break shows one cycle after the matching cycle
		d.brk = pc_hit || (q.ram_arm && ram_hit) // [RULE_19]
		      || (q.reg_arm && cpu_step_in && reg_hit) || (q.comb_arm && comb_hit);
		// events win over a same-cycle write-one clear
		if (d.brk) begin
			d.irq_st[EBC_IRQ_BREAK] = 1'b1;
		end
		if (pc_add && pc_full) begin
			d.irq_st[EBC_IRQ_FULL] = 1'b1;
		end
		d.irq = |(d.irq_st & d.irq_mk);
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign prdata_out    = q.prdata;
	assign pready_out    = q.pready;
	assign pslverr_out   = q.pslverr;
	assign break_req_out = q.brk;
	assign irq_out       = q.irq;

	property p_pc_break;
		@(posedge clk_in) disable iff (!resetn_in)
		(cpu_step_in && pc_match) |=> break_req_out;
	endproperty
	a_pc_break: assert property (p_pc_break) else $error("pc match gave no break"); // [RULE_01]

	property p_clr_quiet;
		@(posedge clk_in) disable iff (!resetn_in)
		pc_clr |=> $stable(q.irq_st[EBC_IRQ_FULL]);
	endproperty
	a_clr_quiet: assert property (p_clr_quiet) else $error("pc clear raised an error flag"); // [RULE_03]

	property p_resume_clear;
		@(posedge clk_in) disable iff (!resetn_in)
		(cpu_resume_in && q.resume_clear_select) |=> !pc_any;
	endproperty
	a_resume_clear: assert property (p_resume_clear) else $error("pc set survived resume clear"); // [RULE_04]

	property p_ram_break;
		@(posedge clk_in) disable iff (!resetn_in)
		(q.ram_arm && ram_access_in && ram_addr_in == q.ram_cond[EBC_RA_W-1:0]
		 && ((ram_data_in ^ q.ram_cond[EBC_RAM_DATA_LSB +: 4]) & ~dmask) == 4'h0
		 && dir == EBC_DIR_ANY) |=> break_req_out;
	endproperty
	a_ram_break: assert property (p_ram_break) else $error("ram match gave no break"); // [RULE_05]

	property p_reg_break;
		@(posedge clk_in) disable iff (!resetn_in)
		(q.reg_arm && cpu_step_in && q.mask[7:0] == 8'hff) |=> break_req_out ##0 q.irq_st[EBC_IRQ_BREAK];
	endproperty
	a_reg_break: assert property (p_reg_break) else $error("masked register condition gave no break"); // [RULE_09]

	property p_comb_disarms;
		@(posedge clk_in) disable iff (!resetn_in)
		(cmd_go && cmd == EBC_CMD_COMB_SET) |=> q.comb_arm && !q.ram_arm && !q.reg_arm && !pc_any;
	endproperty
	a_comb_disarms: assert property (p_comb_disarms) else $error("combined arm left others armed"); // [RULE_14]

	property p_arm_drops_comb;
		@(posedge clk_in) disable iff (!resetn_in)
		(cmd_go && (cmd == EBC_CMD_PC_ADD || cmd == EBC_CMD_RAM_SET || cmd == EBC_CMD_REG_SET))
		|=> !q.comb_arm;
	endproperty
	a_arm_drops_comb: assert property (p_arm_drops_comb) else $error("combined stayed armed"); // [RULE_15]

	property p_comb_needs_ram;
		@(posedge clk_in) disable iff (!resetn_in)
		(q.comb_arm && !ram_access_in) |=> !break_req_out;
	endproperty
	a_comb_needs_ram: assert property (p_comb_needs_ram) else $error("combined broke without ram access"); // [RULE_17]

	property p_clear_all;
		@(posedge clk_in) disable iff (!resetn_in)
		(cmd_go && cmd == EBC_CMD_CLR_ALL)
		|=> !q.ram_arm && !q.reg_arm && !q.comb_arm && !pc_any && $stable(q.resume_clear_select);
	endproperty
	a_clear_all: assert property (p_clear_all) else $error("clear all left a condition armed"); // [RULE_18]

	property p_irq_level;
		@(posedge clk_in) disable iff (!resetn_in)
		(break_req_out && q.irq_mk[EBC_IRQ_BREAK]) |-> irq_out;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("unmasked break gave no interrupt");

	c_pc_break: cover property (@(posedge clk_in) disable iff (!resetn_in) cpu_step_in && pc_match);
	c_ram_break: cover property (@(posedge clk_in) disable iff (!resetn_in) q.ram_arm && ram_hit);
	c_comb_break: cover property (@(posedge clk_in) disable iff (!resetn_in) q.comb_arm && comb_hit);
	c_table_full: cover property (@(posedge clk_in) disable iff (!resetn_in) pc_add && pc_full);
	c_comb_anyaddr: cover property (@(posedge clk_in) disable iff (!resetn_in) q.comb_arm && comb_hit && !addr_eq);
endmodule

// ---- rtl/ebc_pkg.sv ----
// package: constants of the emulator break comparator
package ebc_pkg;
	localparam int EBC_PC_W    = 12;
	localparam int EBC_RA_W    = 12;
	localparam int EBC_XY_W    = 12;
	localparam int EBC_SLOTS   = 8;
	localparam int EBC_ADDR_W  = 8;

	// apb byte offsets
	localparam logic [7:0] EBC_OFF_CTRL   = 8'h00;
	localparam logic [7:0] EBC_OFF_CMD    = 8'h04;
	localparam logic [7:0] EBC_OFF_PC_LO  = 8'h08;
	localparam logic [7:0] EBC_OFF_PC_HI  = 8'h0c;
	localparam logic [7:0] EBC_OFF_RAM    = 8'h10;
	localparam logic [7:0] EBC_OFF_REG_AB = 8'h14;
	localparam logic [7:0] EBC_OFF_REG_XY = 8'h18;
	localparam logic [7:0] EBC_OFF_MASK   = 8'h1c;
	localparam logic [7:0] EBC_OFF_STATUS = 8'h20;
	localparam logic [7:0] EBC_OFF_IRQ_ST = 8'h24;
	localparam logic [7:0] EBC_OFF_IRQ_MK = 8'h28;

	// command codes written to the command register
	localparam logic [3:0] EBC_CMD_PC_ADD   = 4'h1;
	localparam logic [3:0] EBC_CMD_PC_CLR   = 4'h2;
	localparam logic [3:0] EBC_CMD_RAM_SET  = 4'h3;
	localparam logic [3:0] EBC_CMD_RAM_CLR  = 4'h4;
	localparam logic [3:0] EBC_CMD_REG_SET  = 4'h5;
	localparam logic [3:0] EBC_CMD_REG_CLR  = 4'h6;
	localparam logic [3:0] EBC_CMD_COMB_SET = 4'h7;
	localparam logic [3:0] EBC_CMD_COMB_CLR = 4'h8;
	localparam logic [3:0] EBC_CMD_CLR_ALL  = 4'h9;

	// ram condition field positions
	localparam int EBC_RAM_DATA_LSB = 12;
	localparam int EBC_RAM_MASK_LSB = 16;
	localparam int EBC_RAM_DIR_LSB  = 20;
	localparam logic [1:0] EBC_DIR_ANY   = 2'h0;
	localparam logic [1:0] EBC_DIR_READ  = 2'h1;
	localparam logic [1:0] EBC_DIR_WRITE = 2'h2;

	// register condition field positions: a, b, flags {i,d,z,c}
	localparam int EBC_REG_B_LSB  = 4;
	localparam int EBC_REG_FL_LSB = 8;
	localparam int EBC_REG_Y_LSB  = 16;

	// mask bits: a, b, i, d, z, c, x, y, pc, ram address (combined only)
	localparam int EBC_MSK_W    = 10;
	localparam int EBC_MSK_PC   = 8;
	localparam int EBC_MSK_ADDR = 9;

	// irq bits
	localparam int EBC_IRQ_W     = 2;
	localparam int EBC_IRQ_BREAK = 0;
	localparam int EBC_IRQ_FULL  = 1;

	localparam logic [31:0] EBC_RST_WORD = 32'h0000_0000;
endpackage

// ---- rtl/ebc_pc_table.sv ----
// file: pc match set of single addresses and inclusive ranges
`timescale 1ns/10ps
module ebc_pc_table
	import ebc_pkg::*;
#(
	parameter int SLOTS = EBC_SLOTS,
	parameter int PC_W  = EBC_PC_W
) (
	input  wire logic            clk_in,
	input  wire logic            resetn_in,
	input  wire logic            add_in,
	input  wire logic            clr_in,
	input  wire logic            flush_in,
	input  wire logic [PC_W-1:0] lo_in,
	input  wire logic [PC_W-1:0] hi_in,
	input  wire logic [PC_W-1:0] pc_in,
	output logic                 match_out,
	output logic                 any_out,
	output logic                 full_out
);
	typedef struct packed {
		logic [SLOTS-1:0]           vld;
		logic [SLOTS-1:0][PC_W-1:0] lo;
		logic [SLOTS-1:0][PC_W-1:0] hi;
	} ebc_tab_t;

	ebc_tab_t         q, d;
	logic [SLOTS-1:0] hit;
	logic [SLOTS-1:0] gone;
	logic [SLOTS-1:0] free_one;

	genvar gi;
	generate
		for (gi = 0; gi < SLOTS; gi++) begin : g_slot
			assign hit[gi]  = q.vld[gi] && pc_in >= q.lo[gi] && pc_in <= q.hi[gi]; // [RULE_01]
			// entries fully inside the clear range go; unknown ones are simply ignored
			assign gone[gi] = clr_in && q.lo[gi] >= lo_in && q.hi[gi] <= hi_in; // [RULE_03]
			if (gi == 0) begin : g_first
				assign free_one[gi] = ~q.vld[gi];
			end else begin : g_rest
				assign free_one[gi] = ~q.vld[gi] && (&q.vld[gi-1:0]);
			end
		end
	endgenerate

	always_comb begin
		d = q;
		d.vld = q.vld & ~gone;
		if (add_in) begin
			for (int i = 0; i < SLOTS; i++) begin
				if (free_one[i]) begin
					d.vld[i] = 1'b1; // [RULE_02]
					d.lo[i]  = lo_in;
					d.hi[i]  = (hi_in < lo_in) ? lo_in : hi_in;
				end
			end
		end
		if (flush_in) begin
			d.vld = '0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign match_out = |hit;
	assign any_out   = |q.vld;
	assign full_out  = &q.vld;

	property p_add_keeps;
		@(posedge clk_in) disable iff (!resetn_in)
		(any_out && !clr_in && !flush_in) |=> any_out;
	endproperty
	a_add_keeps: assert property (p_add_keeps) else $error("armed pc entry lost without a clear"); // [RULE_02]

	property p_add_fills;
		@(posedge clk_in) disable iff (!resetn_in)
		(add_in && !full_out && !flush_in) |=> any_out;
	endproperty
	a_add_fills: assert property (p_add_fills) else $error("pc add did not arm an entry"); // [RULE_01]
endmodule

// ---- sim/ebc_cpu_model.sv ----
// emulated cpu core model driving the comparator's execution and ram access side
`timescale 1ns/10ps
module ebc_cpu_model
	import ebc_pkg::*;
(
	input  wire logic                clk_in,
	input  wire logic                go_in,
	input  wire logic                step_in,
	input  wire logic                acc_in,
	input  wire logic                wr_in,
	input  wire logic [EBC_PC_W-1:0] pc_in,
	input  wire logic [EBC_RA_W-1:0] addr_in,
	input  wire logic [3:0]          data_in,
	output logic                     step_out,
	output logic                     acc_out,
	output logic                     wr_out,
	output logic      [EBC_PC_W-1:0] pc_out,
	output logic      [EBC_RA_W-1:0] addr_out,
	output logic      [3:0]          data_out
);
	initial begin
		step_out = 1'b0;
		acc_out = 1'b0;
		wr_out = 1'b0;
		pc_out = 12'h000;
		addr_out = 12'h000;
		data_out = 4'h0;
	end

	// one cycle of activity per request, then the buses are released
	always @(posedge clk_in) begin
		if (go_in) begin
			step_out <= step_in;
			acc_out <= acc_in;
			wr_out <= wr_in;
			pc_out <= pc_in;
			addr_out <= addr_in;
			data_out <= data_in;
		end else begin
			// released: step and access drop, wr holds, pc, address and data invert so a stale value never passes for a live one
			step_out <= 1'b0;
			acc_out <= 1'b0;
			pc_out <= ~pc_out;
			addr_out <= ~addr_out;
			data_out <= ~data_out;
		end
	end
endmodule

// ---- sim/test_ebc_break_comparator.sv ----
// self-checking testbench of the break comparator
`timescale 1ns/10ps
module test_ebc_break_comparator
	import ebc_pkg::*;
;
	typedef struct packed {
		logic st; logic [11:0] pc; logic ac; logic wr; logic [11:0] ra; logic [3:0] rd;
		logic [3:0] a; logic [3:0] fl; logic [11:0] x; logic [11:0] y; logic ex;
	} ebc_row_t;
	logic        clk_in = 1'b0;
	logic        resetn_in = 1'b0;
	logic        psel_in = 1'b0;
	logic        penable_in = 1'b0;
	logic        pwrite_in = 1'b0;
	logic [7:0]  paddr_in = 8'h00;
	logic [31:0] pwdata_in = 32'h0;
	logic [31:0] prdata_out, rdat;
	logic        pready_out, pslverr_out, break_req_out, irq_out, rerr;
	logic        go = 1'b0, stp = 1'b0, acc = 1'b0, wrt = 1'b0, resume = 1'b0;
	logic [11:0] pc = 12'h0, ra = 12'h0, rx = 12'h0, ry = 12'h0;
	logic [3:0]  rd = 4'h0, ra_reg = 4'h0, fl = 4'h0;
	logic        m_step, m_acc, m_wr;
	logic [11:0] m_pc, m_addr;
	logic [3:0]  m_data;
	int          n_fail = 0;
	int          cmp_count = 0;
	ebc_row_t    rows [16] = '{
		'{1'b1, 12'h0ff, 1'b0, 1'b0, 12'h000, 4'h0, 4'h0, 4'h0, 12'h000, 12'h000, 1'b0},
		'{1'b1, 12'h100, 1'b0, 1'b0, 12'h000, 4'h0, 4'h0, 4'h0, 12'h000, 12'h000, 1'b1},
		'{1'b1, 12'h105, 1'b0, 1'b0, 12'h000, 4'h0, 4'h0, 4'h0, 12'h000, 12'h000, 1'b1},
		'{1'b1, 12'h106, 1'b0, 1'b0, 12'h000, 4'h0, 4'h0, 4'h0, 12'h000, 12'h000, 1'b0},
		'{1'b1, 12'h3ff, 1'b0, 1'b0, 12'h000, 4'h0, 4'h0, 4'h0, 12'h000, 12'h000, 1'b1},
		'{1'b0, 12'h100, 1'b0, 1'b0, 12'h000, 4'h0, 4'h0, 4'h0, 12'h000, 12'h000, 1'b0},
		'{1'b1, 12'h200, 1'b1, 1'b1, 12'h074, 4'hf, 4'h0, 4'h0, 12'h000, 12'h000, 1'b1},
		'{1'b1, 12'h200, 1'b1, 1'b1, 12'h074, 4'hb, 4'h0, 4'h0, 12'h000, 12'h000, 1'b1},
		'{1'b1, 12'h200, 1'b1, 1'b1, 12'h074, 4'h5, 4'h0, 4'h0, 12'h000, 12'h000, 1'b0},
		'{1'b1, 12'h200, 1'b1, 1'b0, 12'h074, 4'hf, 4'h0, 4'h0, 12'h000, 12'h000, 1'b0},
		'{1'b1, 12'h200, 1'b1, 1'b1, 12'h075, 4'hf, 4'h0, 4'h0, 12'h000, 12'h000, 1'b0},
		'{1'b1, 12'h200, 1'b0, 1'b0, 12'h000, 4'h0, 4'hc, 4'h8, 12'h041, 12'h030, 1'b1},
		'{1'b1, 12'h200, 1'b0, 1'b0, 12'h000, 4'h0, 4'hc, 4'hd, 12'h041, 12'h030, 1'b1},
		'{1'b1, 12'h200, 1'b0, 1'b0, 12'h000, 4'h0, 4'hc, 4'ha, 12'h041, 12'h030, 1'b0},
		'{1'b1, 12'h200, 1'b0, 1'b0, 12'h000, 4'h0, 4'hc, 4'h8, 12'h042, 12'h030, 1'b0},
		'{1'b0, 12'h200, 1'b0, 1'b0, 12'h000, 4'h0, 4'hc, 4'h8, 12'h041, 12'h030, 1'b0}};

	always #10 clk_in = ~clk_in;

	ebc_cpu_model u_cpu (.clk_in(clk_in), .go_in(go), .step_in(stp), .acc_in(acc), .wr_in(wrt), .pc_in(pc),
		.addr_in(ra), .data_in(rd), .step_out(m_step), .acc_out(m_acc), .wr_out(m_wr), .pc_out(m_pc),
		.addr_out(m_addr), .data_out(m_data));

	ebc_break_comparator #(.SLOTS(2)) u_dut (.clk_in(clk_in), .resetn_in(resetn_in), .psel_in(psel_in),
		.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
		.prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .cpu_step_in(m_step),
		.cpu_resume_in(resume), .cpu_pc_in(m_pc), .ram_access_in(m_acc), .ram_write_in(m_wr),
		.ram_addr_in(m_addr), .ram_data_in(m_data), .reg_a_in(ra_reg), .reg_b_in(ra_reg),
		.interrupt_flag_in(fl[3]), .decimal_flag_in(fl[2]), .zero_flag_in(fl[1]), .carry_flag_in(fl[0]),
		.reg_x_in(rx), .reg_y_in(ry), .break_req_out(break_req_out), .irq_out(irq_out));

	task conclude;
		if (n_fail == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		int n;
		@(posedge clk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= ad;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		n = 0;
		// pready looked at mid-cycle; the transfer completes at the next rising edge
		do begin
			@(negedge clk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 64);
		if (n >= 64) n_fail++;
		rdat = prdata_out;
		rerr = pslverr_out;
		@(posedge clk_in);
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask

	task wr(input logic [7:0] ad, input logic [31:0] d);
		apb(1'b1, ad, d);
	endtask

	task rdchk(input logic [7:0] ad, input logic [31:0] exp);
		apb(1'b0, ad, 32'h0);
		check(rdat, exp);
	endtask

	task cmd(input logic [3:0] c);
		wr(EBC_OFF_CMD, {28'h0, c});
	endtask

	task pc_set(input logic [11:0] lo, input logic [11:0] hi, input logic [3:0] c);
		wr(EBC_OFF_PC_LO, {20'h0, lo});
		wr(EBC_OFF_PC_HI, {20'h0, hi});
		cmd(c);
	endtask

	// break must show exactly in the cycle after the matching cycle
	task cpu(input ebc_row_t r);
		@(posedge clk_in);
		{go, stp, pc, acc, wrt, ra, rd} <= {1'b1, r.st, r.pc, r.ac, r.wr, r.ra, r.rd};
		{ra_reg, fl, rx, ry} <= {r.a, r.fl, r.x, r.y};
		@(posedge clk_in);
		go <= 1'b0;
		@(posedge clk_in);
		#1 check({31'h0, break_req_out}, {31'h0, r.ex});
		@(posedge clk_in);
		#1 check({31'h0, break_req_out}, 32'h0);
	endtask

	function automatic ebc_row_t mk(input logic [11:0] p, input logic ac, input logic [3:0] a,
		input logic [11:0] x, input logic [11:0] y, input logic ex);
		return '{1'b1, p, ac, 1'b1, 12'h074, 4'hf, a, 4'h8, x, y, ex};
	endfunction

	task pulse_resume;
		@(posedge clk_in);
		resume <= 1'b1;
		@(posedge clk_in);
		resume <= 1'b0;
	endtask

	initial begin
		// far longer than the whole sequence needs
		#200000;
		n_fail++;
		conclude;
	end

	initial begin
		repeat (3) @(posedge clk_in);
		resetn_in <= 1'b1;
		#1 check({30'h0, irq_out, break_req_out}, 32'h0);
		rdchk(EBC_OFF_STATUS, 32'h0);
		pc_set(12'h100, 12'h105, EBC_CMD_PC_ADD);
		pc_set(12'h3ff, 12'h3ff, EBC_CMD_PC_ADD);
		wr(EBC_OFF_RAM, 32'h0025_a074);
		cmd(EBC_CMD_RAM_SET);
		wr(EBC_OFF_REG_AB, 32'h0000_080c);
		wr(EBC_OFF_REG_XY, 32'h0030_0041);
		wr(EBC_OFF_MASK, 32'h0000_002a);
		cmd(EBC_CMD_REG_SET);
		rdchk(EBC_OFF_STATUS, 32'h17);
		for (int i = 0; i < 16; i++)
			cpu(rows[i]);
		pc_set(12'h0f0, 12'h10f, EBC_CMD_PC_CLR);
		check({31'h0, rerr}, 32'h0);
		rdchk(EBC_OFF_IRQ_ST, 32'h1);
		cpu(rows[1] ^ 1'b1);
		cpu(rows[4]);
		pc_set(12'h500, 12'h500, EBC_CMD_PC_ADD);
		pc_set(12'h600, 12'h600, EBC_CMD_PC_ADD);
		rdchk(EBC_OFF_STATUS, 32'h17);
		rdchk(EBC_OFF_IRQ_ST, 32'h3);
		check({31'h0, irq_out}, 32'h0);
		wr(EBC_OFF_IRQ_MK, 32'h1);
		@(posedge clk_in);
		#1 check({31'h0, irq_out}, 32'h1);
		wr(EBC_OFF_IRQ_ST, 32'h3);
		@(posedge clk_in);
		#1 check({31'h0, irq_out}, 32'h0);
		wr(EBC_OFF_CTRL, 32'h1);
		pulse_resume;
		rdchk(EBC_OFF_STATUS, 32'h06);
		cpu(rows[4] ^ 1'b1);
		wr(EBC_OFF_CTRL, 32'h0);
		pc_set(12'h3ff, 12'h3ff, EBC_CMD_PC_ADD);
		pulse_resume;
		rdchk(EBC_OFF_STATUS, 32'h07);
		cmd(EBC_CMD_RAM_CLR);
		rdchk(EBC_OFF_STATUS, 32'h05);
		cpu(rows[6] ^ 1'b1);
		cpu(rows[11]);
		cmd(EBC_CMD_RAM_SET);
		pc_set(12'h200, 12'h200, EBC_CMD_COMB_SET);
		rdchk(EBC_OFF_STATUS, 32'h08);
		cpu(mk(12'h200, 1'b1, 4'hc, 12'h041, 12'h030, 1'b1));
		cpu(mk(12'h200, 1'b0, 4'hc, 12'h041, 12'h030, 1'b0));
		cpu(mk(12'h201, 1'b1, 4'hc, 12'h041, 12'h030, 1'b0));
		wr(EBC_OFF_MASK, 32'h0000_012a);
		cpu(mk(12'h201, 1'b1, 4'hc, 12'h041, 12'h030, 1'b1));
		pc_set(12'h3ff, 12'h3ff, EBC_CMD_PC_ADD);
		rdchk(EBC_OFF_STATUS, 32'h01);
		wr(EBC_OFF_REG_XY, 32'h0fff_0fff);
		rdchk(EBC_OFF_REG_XY, 32'h0fff_0fff);
		cmd(EBC_CMD_REG_SET);
		cpu(mk(12'h300, 1'b0, 4'hc, 12'hfff, 12'hfff, 1'b1));
		wr(EBC_OFF_CTRL, 32'h1);
		cmd(EBC_CMD_CLR_ALL);
		rdchk(EBC_OFF_STATUS, 32'h0);
		rdchk(EBC_OFF_CTRL, 32'h1);
		cpu(rows[4] ^ 1'b1);
		// unmapped word: refused with an error and zero data
		apb(1'b0, 8'h3c, 32'h0);
		check({rdat[30:0], rerr}, 32'h1);
		// reset in mid-run must drop the mode bit too
		resetn_in <= 1'b0;
		@(posedge clk_in);
		resetn_in <= 1'b1;
		rdchk(EBC_OFF_CTRL, 32'h0);
		wr(EBC_OFF_RAM, 32'h0010_f074);
		cmd(EBC_CMD_RAM_SET);
		cpu(rows[9] ^ 1'b1);
		cpu(rows[6] ^ 1'b1);
		wr(EBC_OFF_RAM, 32'h0000_f074);
		cpu(rows[9] ^ 1'b1);
		wr(EBC_OFF_REG_AB, 32'h0000_0050);
		wr(EBC_OFF_MASK, 32'h0000_01fd);
		cmd(EBC_CMD_REG_SET);
		cpu(rows[0]);
		cpu(mk(12'h0ff, 1'b0, 4'h5, 12'h000, 12'h000, 1'b1));
		wr(EBC_OFF_MASK, 32'h0000_00ff);
		cpu(rows[0] ^ 1'b1);
		wr(EBC_OFF_MASK, 32'h0000_03ff);
		cmd(EBC_CMD_COMB_SET);
		cpu(rows[10] ^ 1'b1);
		wr(EBC_OFF_MASK, 32'h0000_01ff);
		cpu(rows[10]);
		conclude;
	end
endmodule
